// file: rtl/tpr_pkg.sv
// Purpose: shared constants, field layouts and types of the dual 8-bit timer pair
// Assumes: registers sit one per aligned 32-bit word, byte address four times the index
// Notes: data sit in bits 7:0 of each word, status in bits 16:0; upper bits read as zero
`default_nettype none
package tpr_pkg;
  // register indices and their byte addresses
  localparam logic [11:0] RUN_IDX = 12'h100;
  localparam logic [11:0] CH0_IDX = 12'h102;
  localparam logic [11:0] CH1_IDX = 12'h103;
  localparam logic [11:0] MODE_IDX = 12'h104;
  localparam logic [11:0] FFC_IDX = 12'h105;
  localparam logic [11:0] CFG_IDX = 12'h106;
  localparam logic [11:0] STAT_IDX = 12'h107;
  localparam logic [11:0] RUN_ADDR = {RUN_IDX[9:0], 2'b00};
  localparam logic [11:0] CH0_ADDR = {CH0_IDX[9:0], 2'b00};
  localparam logic [11:0] CH1_ADDR = {CH1_IDX[9:0], 2'b00};
  localparam logic [11:0] MODE_ADDR = {MODE_IDX[9:0], 2'b00};
  localparam logic [11:0] FFC_ADDR = {FFC_IDX[9:0], 2'b00};
  localparam logic [11:0] CFG_ADDR = {CFG_IDX[9:0], 2'b00};
  localparam logic [11:0] STAT_ADDR = {STAT_IDX[9:0], 2'b00};
  // reset values
  localparam logic [7:0] RUN_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] FFC_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  // prescaler: base divide by four, taps as prescaler bit counts
  localparam logic [2:0] BASE_LOG = 3'h2;
  localparam logic [2:0] GEAR_MAX = 3'h4;
  localparam logic [1:0] SRC_FC16 = 2'h2;
  localparam logic [3:0] TAP_T1 = 4'h1;
  localparam logic [3:0] TAP_T4 = 4'h3;
  localparam logic [3:0] TAP_T16 = 4'h5;
  localparam logic [3:0] TAP_T256 = 4'h9;
  // toggle flop force codes, counter limits, pwm period codes
  localparam logic [1:0] FORCE_INV = 2'h0;
  localparam logic [1:0] FORCE_CLR = 2'h1;
  localparam logic [1:0] FORCE_SET = 2'h2;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] PWM_TOP6 = 8'h3F;
  localparam logic [7:0] PWM_TOP7 = 8'h7F;
  localparam logic [1:0] PWM_P6 = 2'h1;
  localparam logic [1:0] PWM_P7 = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {TPR_TWO8, TPR_CASC16, TPR_PPG, TPR_PWM} tpr_mode_e;

  typedef struct packed {
    logic double_buffer_enable;
    logic [3:0] rsv;
    logic prescaler_run_bit;
    logic channel1_run_bit;
    logic channel0_run_bit;
  } tpr_run_s;

  typedef struct packed {
    logic [1:0] pair_mode_field;
    logic [1:0] pwm_period;
    logic [1:0] counter_clock_select;
    logic [1:0] ch0_clock_select;
  } tpr_mode_s;

  typedef struct packed {
    logic [2:0] rsv;
    logic [1:0] prescaler_source_select;
    logic [2:0] clock_gear_field;
  } tpr_cfg_s;
endpackage
`default_nettype wire

// file: rtl/tpr_timer_pair.sv
// Purpose: dual 8-bit timer pair with shared prescaler and toggle flop, AHB-Lite slave
// Assumes: hclk is the system clock fc; only haddr[11:0] is decoded
// Notes: reads take one wait state, writes none; response is always OKAY
//
// Summary of operation
// - four modes: two 8-bit timers, cascaded 16-bit, pulse generator, pwm
// - each channel has counter, comparator, register; prescaler and toggle flop shared
// - 9-bit prescaler fed by gear clock or fc/16, divided by four
// - prescaler run bit set counts; cleared zeroes and halts prescaler
// - taps fc/2^3,2^5,2^7,2^11 at gear 0, doubling per gear step
// - channel 0 clock: external pin or one of three fastest taps
// - channel 1 clock: ch0 overflow when cascaded, else tap or ch0 match
// - run bit counts when set, stops and clears when cleared; reset stops both
// - match when counter reaches register; zero register matches on overflow
// - in two-timer mode a match clears that counter and pulses that channel's interrupt
// - double buffer enable bit for first register, reset to zero
// - buffer copied in at pwm period end or pulse period start only
// - one address: buffering off writes both, on writes buffer only
// - compare registers are write-only and read as zero
// - enabled toggle flop inverts on match, same cycle as counter clear
// - reset clears toggle flop; force field 01 clears, 10 sets, 00 inverts
// - mode field 00 two timers, 01 cascade, 10 pulse gen, 11 pwm
// - cascade: only both matching together clears both, irq1, toggles flop
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`default_nettype none
module tpr_timer_pair (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic external_count_input,
  output logic toggle_output_pin,
  output logic channel0_irq,
  output logic channel1_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // low k bits of the prescaler all ones: the tap fires on the next increment
  function automatic logic tap_hit(input logic [8:0] pre, input logic [3:0] k);
    logic [8:0] m;
    m = 9'((10'h1 << k) - 10'h1);
    return (pre & m) == m;
  endfunction

  // byte address decode on the low address bits
  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
    return a == ref_a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic rd_q, wr_q;
  logic [11:0] addr_q;
  logic [31:0] hrdata_q;
  tpr_pkg::tpr_run_s run_q;
  tpr_pkg::tpr_mode_s mode_q;
  tpr_pkg::tpr_cfg_s cfg_q;
  logic [1:0] ffc_q;
  logic [7:0] reg0_q, buf0_q, reg1_q;
  logic [7:0] cnt0_q, cnt1_q;
  logic ff_q;

  // a word-sized nonseq or seq transfer to this slave opens an address phase
  wire ap_valid = hsel && htrans[1] && hready && (hsize == tpr_pkg::HSIZE_WORD);
  wire ap_rd = ap_valid && !hwrite;
  wire ap_wr = ap_valid && hwrite;

  // read waits one cycle so a write just before it is always visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      rd_q <= ap_rd;
      wr_q <= ap_wr;
      if (ap_valid) begin
        addr_q <= haddr[11:0];
      end
    end
  end

  wire sel_run = is_addr(addr_q, tpr_pkg::RUN_ADDR);
  wire sel_ch0 = is_addr(addr_q, tpr_pkg::CH0_ADDR);
  wire sel_ch1 = is_addr(addr_q, tpr_pkg::CH1_ADDR);
  wire sel_mode = is_addr(addr_q, tpr_pkg::MODE_ADDR);
  wire sel_ffc = is_addr(addr_q, tpr_pkg::FFC_ADDR);
  wire sel_cfg = is_addr(addr_q, tpr_pkg::CFG_ADDR);
  wire sel_stat = is_addr(addr_q, tpr_pkg::STAT_ADDR);
  wire [7:0] wbyte = hwdata[7:0];
  wire wr_run = wr_q && sel_run;
  wire wr_ch0 = wr_q && sel_ch0;
  wire wr_ch1 = wr_q && sel_ch1;
  wire wr_mode = wr_q && sel_mode;
  wire wr_ffc = wr_q && sel_ffc;
  wire wr_cfg = wr_q && sel_cfg;

  // read mux; compare registers are not readable, force field reads as 11
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (sel_run) rd_val[7:0] = {run_q.double_buffer_enable, 4'h0, run_q[2:0]};
    if (sel_mode) rd_val[7:0] = mode_q;
    if (sel_ffc) rd_val[7:0] = {4'h0, 2'h3, ffc_q};
    if (sel_cfg) rd_val[7:0] = cfg_q;
    if (sel_stat) rd_val[16:0] = {ff_q, cnt1_q, cnt0_q};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else begin
      hrdata_q <= rd_q ? rd_val : 32'h0000_0000;
    end
  end

  assign hreadyout = !rd_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= tpr_pkg::RUN_RST;
      mode_q <= tpr_pkg::MODE_RST;
      cfg_q <= tpr_pkg::CFG_RST;
      ffc_q <= tpr_pkg::FFC_RST[1:0];
      reg1_q <= tpr_pkg::CMP_RST;
    end else begin
      if (wr_run) run_q <= {wbyte[7], 4'h0, wbyte[2:0]};
      if (wr_mode) mode_q <= wbyte;
      if (wr_cfg) cfg_q <= {3'h0, wbyte[4:0]};
      if (wr_ffc) ffc_q <= wbyte[1:0];
      if (wr_ch1) reg1_q <= wbyte;
    end
  end

  wire tpr_pkg::tpr_mode_e mode = tpr_pkg::tpr_mode_e'(mode_q.pair_mode_field);
  wire is_two8 = (mode == tpr_pkg::TPR_TWO8);
  wire is_casc = (mode == tpr_pkg::TPR_CASC16);
  wire is_ppg = (mode == tpr_pkg::TPR_PPG);
  wire is_pwm = (mode == tpr_pkg::TPR_PWM);

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler

  logic [5:0] div_q;
  logic [8:0] pre_q;

  // fc/16 source behaves as the slowest gear; undefined gear codes clamp to it
  wire [2:0] gear = (cfg_q.prescaler_source_select == tpr_pkg::SRC_FC16) ? tpr_pkg::GEAR_MAX :
                    (cfg_q.clock_gear_field > tpr_pkg::GEAR_MAX) ? tpr_pkg::GEAR_MAX :
                    cfg_q.clock_gear_field;
  wire [6:0] div_span = 7'h01 << (gear + tpr_pkg::BASE_LOG);
  wire [5:0] div_mask = 6'(div_span - 7'h01);
  wire base_tick = run_q.prescaler_run_bit && ((div_q & div_mask) == div_mask);
  wire t1 = base_tick && tap_hit(pre_q, tpr_pkg::TAP_T1);
  wire t4 = base_tick && tap_hit(pre_q, tpr_pkg::TAP_T4);
  wire t16 = base_tick && tap_hit(pre_q, tpr_pkg::TAP_T16);
  wire t256 = base_tick && tap_hit(pre_q, tpr_pkg::TAP_T256);

  // run bit low holds divider and prescaler at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 6'h00;
      pre_q <= 9'h000;
    end else if (!run_q.prescaler_run_bit) begin
      div_q <= 6'h00;
      pre_q <= 9'h000;
    end else begin
      div_q <= div_q + 6'h01;
      if (base_tick) pre_q <= pre_q + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // external clock pin: two-flop synchroniser, then rising edge detect

  logic ext_s1_q, ext_s2_q, ext_s3_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_count_input;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  wire ext_tick = ext_s2_q && !ext_s3_q;

  ////////////////////////////////////////////////////////////////////////////////
  // counters and comparators

  logic clk0_sel, clk1_sel;
  // channel 0 source
  always_comb begin
    unique case (mode_q.ch0_clock_select)
      2'h0: clk0_sel = ext_tick;
      2'h1: clk0_sel = t1;
      2'h2: clk0_sel = t4;
      2'h3: clk0_sel = t16;
    endcase
  end

  wire tick0 = run_q.channel0_run_bit && clk0_sel;
  wire [7:0] nxt0 = cnt0_q + 8'h01;
  wire ovf0 = tick0 && (cnt0_q == tpr_pkg::CNT_MAX);
  // next value equal to register; a zero register thus matches on the wrap
  wire hit0 = tick0 && (nxt0 == reg0_q);
  wire hit0_per = tick0 && (nxt0 == reg1_q); // period end in pulse generation
  wire [7:0] pwm_top = (mode_q.pwm_period == tpr_pkg::PWM_P6) ? tpr_pkg::PWM_TOP6 :
                       (mode_q.pwm_period == tpr_pkg::PWM_P7) ? tpr_pkg::PWM_TOP7 :
                       tpr_pkg::CNT_MAX;
  wire pwm_end = tick0 && (cnt0_q == pwm_top - 8'h01);

  // channel 1 source; the ch0 comparator output is its match pulse
  always_comb begin
    unique case (mode_q.counter_clock_select)
      2'h0: clk1_sel = hit0;
      2'h1: clk1_sel = t1;
      2'h2: clk1_sel = t16;
      2'h3: clk1_sel = t256;
    endcase
  end

  wire tick1 = run_q.channel1_run_bit && (is_casc ? ovf0 : clk1_sel);
  wire [7:0] nxt1 = cnt1_q + 8'h01;
  wire [7:0] cnt1_now = tick1 ? nxt1 : cnt1_q;
  wire hit1 = tick1 && (nxt1 == reg1_q);
  wire casc_hit = is_casc && hit0 && (cnt1_now == reg1_q);

  logic [7:0] cnt0_d, cnt1_d;
  // channel 0 clears on its own match only in two-timer mode
  always_comb begin
    cnt0_d = tick0 ? nxt0 : cnt0_q;
    unique case (mode)
      tpr_pkg::TPR_TWO8: if (hit0) cnt0_d = 8'h00;
      tpr_pkg::TPR_CASC16: if (casc_hit) cnt0_d = 8'h00;
      tpr_pkg::TPR_PPG: if (hit0_per) cnt0_d = 8'h00;
      tpr_pkg::TPR_PWM: if (pwm_end) cnt0_d = 8'h00;
    endcase
    if (!run_q.channel0_run_bit) cnt0_d = 8'h00;
  end

  // channel 1 idles in pulse generation mode
  always_comb begin
    cnt1_d = cnt1_now;
    if (is_casc && casc_hit) cnt1_d = 8'h00;
    if (!is_casc && hit1) cnt1_d = 8'h00;
    if (is_ppg || !run_q.channel1_run_bit) cnt1_d = 8'h00;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt0_q <= 8'h00;
      cnt1_q <= 8'h00;
    end else begin
      cnt0_q <= cnt0_d;
      cnt1_q <= cnt1_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // first compare register with its buffer

  wire xfer = run_q.double_buffer_enable &&
              ((is_pwm && pwm_end) || (is_ppg && hit0_per));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg0_q <= tpr_pkg::CMP_RST;
      buf0_q <= tpr_pkg::CMP_RST;
    end else begin
      if (wr_ch0) buf0_q <= wbyte;
      if (wr_ch0 && !run_q.double_buffer_enable) reg0_q <= wbyte;
      else if (xfer) reg0_q <= buf0_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts and shared toggle flop

  wire irq0_ev = hit0;
  wire irq1_ev = is_casc ? casc_hit : (is_ppg ? hit0_per : hit1);
  logic hw_tgl;
  always_comb begin
    unique case (mode)
      tpr_pkg::TPR_TWO8: hw_tgl = ffc_q[0] ? hit1 : hit0;
      tpr_pkg::TPR_CASC16: hw_tgl = casc_hit;
      tpr_pkg::TPR_PPG: hw_tgl = hit0 || hit0_per;
      tpr_pkg::TPR_PWM: hw_tgl = hit0 || pwm_end;
    endcase
  end
  wire tgl = ffc_q[1] && hw_tgl;

  // a software force in the same cycle beats the hardware toggle
  logic ff_d;
  always_comb begin
    ff_d = tgl ? !ff_q : ff_q;
    if (wr_ffc) begin
      unique case (wbyte[3:2])
        tpr_pkg::FORCE_INV: ff_d = !ff_q;
        tpr_pkg::FORCE_CLR: ff_d = 1'b0;
        tpr_pkg::FORCE_SET: ff_d = 1'b1;
        default: ff_d = ff_d;
      endcase
    end
  end

  logic irq0_q, irq1_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ff_q <= 1'b0;
      irq0_q <= 1'b0;
      irq1_q <= 1'b0;
    end else begin
      ff_q <= ff_d;
      irq0_q <= irq0_ev;
      irq1_q <= irq1_ev;
    end
  end

  assign toggle_output_pin = ff_q;
  assign channel0_irq = irq0_q;
  assign channel1_irq = irq1_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_pre_halt;
    !run_q.prescaler_run_bit |=> (pre_q == 9'h000) && !t1;
  endproperty
  a_pre_halt: assert property (p_pre_halt) else $error("prescaler not held");

  property p_run_clear;
    !run_q.channel0_run_bit |=> (cnt0_q == 8'h00) && !channel0_irq;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("stopped counter moved");

  sequence s_match_two8;
    is_two8 && hit0 && !wr_run;
  endsequence
  property p_match_clear;
    s_match_two8 |=> (cnt0_q == 8'h00) && channel0_irq;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match did not clear");

  property p_zero_ovf;
    (reg0_q == 8'h00) && ovf0 |=> channel0_irq;
  endproperty
  a_zero_ovf: assert property (p_zero_ovf) else $error("zero register missed wrap");

  property p_casc_hold;
    is_casc && hit0 && !casc_hit && !wr_run |=> cnt0_q == $past(nxt0);
  endproperty
  a_casc_hold: assert property (p_casc_hold) else $error("cascade cleared early");

  property p_casc_clk;
    is_casc && tick1 |-> ovf0;
  endproperty
  a_casc_clk: assert property (p_casc_clk) else $error("cascade clock not overflow");

  property p_toggle;
    tgl && !wr_ffc |=> ff_q != $past(ff_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle flop did not invert");

  property p_force_set;
    wr_ffc && (wbyte[3:2] == tpr_pkg::FORCE_SET) |=> ff_q ##1 (ff_q || $past(tgl));
  endproperty
  a_force_set: assert property (p_force_set) else $error("force set failed");

  property p_buf_only;
    wr_ch0 && run_q.double_buffer_enable && !xfer |=> reg0_q == $past(reg0_q);
  endproperty
  a_buf_only: assert property (p_buf_only) else $error("buffered write hit register");

  property p_xfer;
    xfer && !wr_ch0 |=> reg0_q == $past(buf0_q);
  endproperty
  a_xfer: assert property (p_xfer) else $error("buffer not transferred");

  sequence s_rd_ch0;
    ap_rd && is_addr(haddr[11:0], tpr_pkg::CH0_ADDR);
  endsequence
  property p_wo_read;
    s_rd_ch0 |=> !hreadyout ##1 (hreadyout && (hrdata == 32'h0000_0000));
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("compare register readable");

endmodule
`default_nettype wire

// file: tb/tpr_pin_model.sv
// Purpose: far-side model, a pulse source on the external count pin
// Assumes: each pulse is 4 clocks high then 4 low; bursts are requested by the bench
// Notes: the source drives the pin low between bursts, as a real pulse generator would
`default_nettype none
module tpr_pin_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [3:0] n_req,
  output logic count_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left_q;
  logic [2:0] ph_q;
  ////////////////////////////////////////////////////////////////////////////
  // burst generator; pulses kept slow so the two-flop sync never misses one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 4'h0;
      ph_q <= 3'h0;
      count_pin <= 1'b0;
    end else if (go) begin
      left_q <= n_req;
      ph_q <= 3'h0;
    end else if (left_q != 4'h0) begin
      ph_q <= ph_q + 3'h1;
      count_pin <= (ph_q < 3'h4);
      if (ph_q == 3'h7) begin
        left_q <= left_q - 4'h1;
      end
    end else begin
      count_pin <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb/tpr_timer_pair_bench.sv
// Purpose: self-checking bench of the timer pair over its AHB-Lite port
// Assumes: gear 0 save in the gear 1 and fc16 checks, so the fastest tap ticks every 8 hclk
// Notes: bus outputs are looked at on the falling edge, where they are settled
`default_nettype none
module tpr_timer_pair_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, go;
  logic [31:0] haddr, hwdata, hrdata, rd, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, ext_in, pin, irq0, irq1, p;
  logic [3:0] n_pulse;
  logic [7:0] codes [4] = '{8'h0A, 8'h06, 8'h02, 8'h02};
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int t0, t1;

  tpr_timer_pair u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .external_count_input(ext_in),
    .toggle_output_pin(pin), .channel0_irq(irq0), .channel1_irq(irq1));
  tpr_pin_model u_pins (.clk(hclk), .rst_n(hresetn), .go(go), .n_req(n_pulse),
    .count_pin(ext_in));

  ////////////////////////////////////////////////////////////////////////////
  // clock and free-running cycle stamp
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // waits for hready sampled high; the master never assumes a latency
  task automatic wait_ready(output logic [31:0] dat);
    int i;
    for (i = 0; i < 50; i++) begin
      @(negedge hclk);
      if (hreadyout === 1'b1) break;
    end
    dat = hrdata;
    if (i == 50) begin
      n_mismatch++;
      conclude();
    end
    @(posedge hclk);
  endtask

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] dat);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= tpr_pkg::HSIZE_WORD;
    wait_ready(dat);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(dat);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    ahb(1'b1, a, wd, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, rd);
    check("register read", exp, rd);
  endtask

  // one irq pulse, stamped; the pulse lasts a single cycle
  task automatic wait_irq(input bit sel, output int t, output logic pv);
    int i;
    for (i = 0; i < 5000; i++) begin
      @(negedge hclk);
      if ((sel ? irq1 : irq0) === 1'b1) break;
    end
    t = cyc;
    pv = pin;
    if (i == 5000) begin
      n_mismatch++;
      conclude();
    end
    @(posedge hclk);
  endtask

  // first pulse only syncs, so a mid-count register change cannot skew it
  task automatic interval(input bit sel, output logic [31:0] dv);
    int a, b, c;
    wait_irq(sel, a, p);
    wait_irq(sel, b, p);
    wait_irq(sel, c, p);
    dv = c - b;
  endtask

  task automatic pulse(input logic [3:0] n);
    go <= 1'b1;
    n_pulse <= n;
    @(posedge hclk);
    go <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = tpr_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    go = 1'b0;
    n_pulse = 4'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("pin after reset", 32'h0, {31'h0, pin});
    rd_chk(tpr_pkg::RUN_ADDR, {24'h0, tpr_pkg::RUN_RST});
    rd_chk(tpr_pkg::MODE_ADDR, {24'h0, tpr_pkg::MODE_RST});
    rd_chk(tpr_pkg::STAT_ADDR, 32'h0);
    wr(tpr_pkg::CH0_ADDR, 32'h03);
    wr(tpr_pkg::CH1_ADDR, 32'h02);
    rd_chk(tpr_pkg::CH0_ADDR, 32'h0);
    rd_chk(tpr_pkg::CH1_ADDR, 32'h0);
    rd_chk(12'h500, 32'h0);
    // two timers, ch0 on the fastest tap, ch1 counting ch0 matches
    wr(tpr_pkg::MODE_ADDR, 32'h01);
    wr(tpr_pkg::FFC_ADDR, 32'h06);
    wr(tpr_pkg::RUN_ADDR, 32'h07);
    wait_irq(1'b0, t0, p);
    check("toggle pin", 32'h1, {31'h0, p});
    wait_irq(1'b0, t1, p);
    check("toggle pin", 32'h0, {31'h0, p});
    check("ch0 irq period", 32'd24, t1 - t0);
    interval(1'b1, d);
    check("ch1 irq period", 32'd48, d);
    // buffered write must not reach the register in interval mode
    wr(tpr_pkg::RUN_ADDR, 32'h87);
    rd_chk(tpr_pkg::RUN_ADDR, 32'h87);
    wr(tpr_pkg::CH0_ADDR, 32'h05);
    interval(1'b0, d);
    check("buffered period", 32'd24, d);
    wr(tpr_pkg::RUN_ADDR, 32'h07);
    wr(tpr_pkg::CH0_ADDR, 32'h05);
    interval(1'b0, d);
    check("direct period", 32'd40, d);
    wr(tpr_pkg::CH0_ADDR, 32'h00);
    interval(1'b0, d);
    check("overflow period", 32'd2048, d);
    wr(tpr_pkg::RUN_ADDR, 32'h00);
    ahb(1'b0, tpr_pkg::STAT_ADDR, 32'h0, rd);
    check("stopped counters", 32'h0, {16'h0, rd[15:0]});
    // external pin as the ch0 clock
    wr(tpr_pkg::MODE_ADDR, 32'h00);
    wr(tpr_pkg::CH0_ADDR, 32'h02);
    wr(tpr_pkg::RUN_ADDR, 32'h01);
    pulse(4'h1);
    repeat (20) @(posedge hclk);
    ahb(1'b0, tpr_pkg::STAT_ADDR, 32'h0, rd);
    check("pin count", 32'h1, {24'h0, rd[7:0]});
    pulse(4'h1);
    wait_irq(1'b0, t0, p);
    ahb(1'b0, tpr_pkg::STAT_ADDR, 32'h0, rd);
    check("cleared count", 32'h0, {24'h0, rd[7:0]});
    // software force codes: set, clear, invert twice
    wr(tpr_pkg::FFC_ADDR, 32'h06);
    for (int k = 0; k < 4; k++) begin
      wr(tpr_pkg::FFC_ADDR, {24'h0, codes[k]});
      @(negedge hclk);
      check("forced pin", {31'h0, k[0] == 1'b0}, {31'h0, pin});
      @(posedge hclk);
    end
    // cascade: 16-bit compare value 0x0102 on T1, so 258 ticks
    wr(tpr_pkg::CH1_ADDR, 32'h01);
    wr(tpr_pkg::MODE_ADDR, 32'h41);
    wr(tpr_pkg::RUN_ADDR, 32'h07);
    interval(1'b1, d);
    check("cascade period", 32'd2064, d);
    // pwm over 2^6-1 ticks, then a buffered compare value
    wr(tpr_pkg::CH0_ADDR, 32'h10);
    wr(tpr_pkg::MODE_ADDR, 32'hD1);
    interval(1'b0, d);
    check("pwm period", 32'd504, d);
    wr(tpr_pkg::RUN_ADDR, 32'h87);
    wr(tpr_pkg::CH0_ADDR, 32'h20);
    // two matches surely straddle a period end, where the buffer moves in
    wait_irq(1'b0, t0, p);
    wait_irq(1'b0, t0, p);
    ahb(1'b0, tpr_pkg::STAT_ADDR, 32'h0, rd);
    check("pwm buffered value", 32'h20, {24'h0, rd[7:0]});
    // pulse generation: first value below second, ch1 run bit set
    wr(tpr_pkg::RUN_ADDR, 32'h07);
    wr(tpr_pkg::CH0_ADDR, 32'h02);
    wr(tpr_pkg::CH1_ADDR, 32'h06);
    wr(tpr_pkg::MODE_ADDR, 32'h81);
    interval(1'b1, d);
    check("pulse period", 32'd48, d);
    wr(tpr_pkg::CFG_ADDR, 32'h01);
    interval(1'b1, d);
    check("gear 1 period", 32'd96, d);
    wr(tpr_pkg::CFG_ADDR, 32'h10);
    interval(1'b1, d);
    check("fc16 period", 32'd768, d);
    conclude();
  end
endmodule
`default_nettype wire
